// ==== design/rsc_strap_config.sv ====
// Purpose: Power-on strap capture with host override register
// Assumes: APB slave, synchronous active-high reset, mclk at 10 MHz
// Notes:   All outputs registered
//
// How it works
// [R1] Capture straps at reset release; bus tri-stated before
// [R2] Override register holds config plus select bit
// [R3] Host write updates override, not strap latches
// [R4] Select zero uses straps, one uses register
// [R5] Reads return straps or register per select
// [R6] Bit nine picks AGP 2X or 1X
// [R7] Bits eight:seven pick TV timing
// [R8] Bit six states crystal frequency
// [R9] Bit four picks 64 or 128-bit bus
// [R10] Bit three exposes power management, changes identifier
// [R11] Bit two declares memory type
// [R12] Bit one picks subsystem ID source
// [R13] Firmware writes subsystem IDs before plug-and-play; no write path here, subsystem IDs stay zero
// [R14] Bit zero sets 66 MHz capability
// [R15] Reset clears override select
`timescale 1ns/1ps
module rsc_strap_config (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [9:0]  framebuffer_addr_pins,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sys_bus_oe,
    output logic             agp_1x,
    output logic [1:0]       tv_mode,
    output logic             tv_enable,
    output logic             xtal_14m,
    output logic             host_agp,
    output logic             ram_128,
    output logic             fb_upper_oe,
    output logic             pm_visible,
    output logic [15:0]      chip_identifier,
    output logic             ram_8mbit,
    output logic             subsys_from_rom,
    output logic [15:0]      subsys_vendor_id,
    output logic [15:0]      subsys_id,
    output logic [7:0]       subsys_rom_addr,
    output logic             pci_66
);

    // ********************************************
    // State
    // ********************************************
    logic       rst_d_reg;
    logic [9:0] strap_reg;
    logic [9:0] ovr_cfg_reg;
    logic       ovr_sel_reg;
    logic       sys_oe_reg;
    logic       setup_ok;
    logic       wr_en;
    logic       rd_en;
    logic       hit_cfg;
    logic       hit_info;
    logic [9:0] sel_cfg;
    logic [31:0] rd_value;

    rsc_cfg_if cfg_bus ();

    rsc_cfg_decode u_decode (
        .c (cfg_bus)
    );

    // ********************************************
    // Strap capture at reset release
    // ********************************************
    always_ff @(posedge mclk) begin
        rst_d_reg <= rst;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            strap_reg <= rsc_pkg::CFG_RESET;
        end else if (rst_d_reg) begin
            strap_reg <= framebuffer_addr_pins; // [R1]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sys_oe_reg <= 1'b0;
        end else if (rst_d_reg) begin
            sys_oe_reg <= 1'b1; // [R1]
        end
    end

    // ********************************************
    // APB decode
    // ********************************************
    assign setup_ok = psel && penable && sys_oe_reg;
    assign hit_cfg  = (paddr == rsc_pkg::BOOT_CFG_ADDR);
    assign hit_info = (paddr == rsc_pkg::DEV_INFO_ADDR);
    // Write lands only at the edge that completes the access
    assign wr_en    = setup_ok && pwrite && hit_cfg && pready; // [R3]
    assign rd_en    = setup_ok && !pwrite;

    // ********************************************
    // Override register
    // ********************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            ovr_cfg_reg <= rsc_pkg::CFG_RESET;
        end else if (wr_en) begin
            if (pstrb[0]) begin
                ovr_cfg_reg[7:0] <= pwdata[7:0]; // [R2] [R3]
            end
            if (pstrb[1]) begin
                ovr_cfg_reg[9:8] <= pwdata[9:8]; // [R3]
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ovr_sel_reg <= 1'b0; // [R15]
        end else if (wr_en && pstrb[1]) begin
            ovr_sel_reg <= pwdata[rsc_pkg::SEL_BIT]; // [R2]
        end
    end

    assign sel_cfg = ovr_sel_reg ? ovr_cfg_reg : strap_reg; // [R4]
    assign cfg_bus.cfg = sel_cfg;

    // ********************************************
    // Read mux
    // ********************************************
    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit_cfg) begin
            rd_value[9:0]             = sel_cfg; // [R5]
            rd_value[rsc_pkg::SEL_BIT] = ovr_sel_reg;
        end else if (hit_info) begin
            rd_value[15:0] = cfg_bus.device_id;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready
                       && !(hit_cfg || (hit_info && !pwrite));
            if (rd_en && !pready) begin
                prdata <= rd_value;
            end
        end
    end

    // ********************************************
    // Registered configuration outputs
    // ********************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            sys_bus_oe <= 1'b0; // [R1]
        end else begin
            sys_bus_oe <= sys_oe_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            agp_1x          <= 1'b0;
            tv_mode         <= 2'h0;
            tv_enable       <= 1'b0;
            xtal_14m        <= 1'b0;
            host_agp        <= 1'b0;
            ram_128         <= 1'b0;
            fb_upper_oe     <= 1'b0;
            pm_visible      <= 1'b0;
            chip_identifier <= rsc_pkg::ID_LEGACY;
            ram_8mbit       <= 1'b0;
            subsys_from_rom <= 1'b0;
            pci_66          <= 1'b0;
        end else begin
            agp_1x          <= cfg_bus.agp_1x; // [R6]
            tv_mode         <= cfg_bus.tv_mode; // [R7]
            tv_enable       <= cfg_bus.tv_enable; // [R7]
            xtal_14m        <= cfg_bus.xtal_14m; // [R8]
            host_agp        <= cfg_bus.host_agp;
            ram_128         <= cfg_bus.ram_128; // [R9]
            fb_upper_oe     <= cfg_bus.ram_128; // [R9]
            pm_visible      <= cfg_bus.pm_visible; // [R10]
            chip_identifier <= cfg_bus.device_id; // [R10]
            ram_8mbit       <= cfg_bus.ram_8mbit; // [R11]
            subsys_from_rom <= cfg_bus.subsys_from_rom; // [R12]
            pci_66          <= cfg_bus.pci_66; // [R14]
        end
    end

    // ********************************************
    // Subsystem ID source
    // ********************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            subsys_vendor_id <= rsc_pkg::SUBSYS_ZERO;
            subsys_id        <= rsc_pkg::SUBSYS_ZERO;
            subsys_rom_addr  <= rsc_pkg::SUBSYS_ROM_BASE;
        end else if (!cfg_bus.subsys_from_rom) begin
            subsys_vendor_id <= rsc_pkg::SUBSYS_ZERO; // [R12]
            subsys_id        <= rsc_pkg::SUBSYS_ZERO; // [R12]
            subsys_rom_addr  <= rsc_pkg::SUBSYS_ROM_BASE;
        end else begin
            subsys_rom_addr  <= rsc_pkg::SUBSYS_ROM_BASE; // [R12]
        end
    end

endmodule

// ==== design/rsc_pkg.sv ====
// Purpose: Constants for the reset strap configuration block
// Assumes: APB slave with 32-bit data, 10 MHz mclk
// Notes:   Offsets are byte addresses
package rsc_pkg;

    // ********************************************
    // Register map
    // ********************************************
    localparam logic [31:0] BOOT_CFG_ADDR   = 32'h0010_1000;
    localparam logic [31:0] DEV_INFO_ADDR   = 32'h0010_1004;

    // ********************************************
    // Field positions
    // ********************************************
    localparam int SEL_BIT                  = 11;
    localparam int AGP_BIT                  = 9;
    localparam int TV_LSB                   = 7;
    localparam int XTAL_BIT                 = 6;
    localparam int HOST_BIT                 = 5;
    localparam int RAMW_BIT                 = 4;
    localparam int ACPI_BIT                 = 3;
    localparam int RAMT_BIT                 = 2;
    localparam int SUBV_BIT                 = 1;
    localparam int BUS66_BIT                = 0;

    // ********************************************
    // Reset values and codes
    // ********************************************
    localparam logic [9:0]  CFG_RESET       = 10'h000;
    localparam logic [1:0]  TV_RESERVED     = 2'h0;
    localparam logic [1:0]  TV_NTSC         = 2'h1;
    localparam logic [1:0]  TV_PAL          = 2'h2;
    localparam logic [1:0]  TV_OFF          = 2'h3;
    localparam logic [15:0] SUBSYS_ZERO     = 16'h0000;
    localparam logic [7:0]  SUBSYS_ROM_BASE = 8'h54;
    // Arbitrary identifier values
    localparam logic [15:0] ID_LEGACY       = 16'h0A10;
    localparam logic [15:0] ID_PM           = 16'h0A11;

    typedef enum logic [1:0] {
        RSC_TV_RESERVED,
        RSC_TV_NTSC,
        RSC_TV_PAL,
        RSC_TV_OFF
    } rsc_tv_mode_t;

endpackage

// ==== design/rsc_cfg_if.sv ====
// Purpose: Carries the selected configuration word to the decoder
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/1ps
interface rsc_cfg_if;
    logic [9:0] cfg;
    logic       agp_1x;
    logic [1:0] tv_mode;
    logic       tv_enable;
    logic       xtal_14m;
    logic       host_agp;
    logic       ram_128;
    logic       pm_visible;
    logic [15:0] device_id;
    logic       ram_8mbit;
    logic       subsys_from_rom;
    logic       pci_66;

    modport src (
        output cfg,
        input  agp_1x, tv_mode, tv_enable, xtal_14m, host_agp, ram_128,
        input  pm_visible, device_id, ram_8mbit, subsys_from_rom, pci_66
    );
    modport dec (
        input  cfg,
        output agp_1x, tv_mode, tv_enable, xtal_14m, host_agp, ram_128,
        output pm_visible, device_id, ram_8mbit, subsys_from_rom, pci_66
    );
endinterface

// ==== design/rsc_cfg_decode.sv ====
// Purpose: Decodes the selected configuration word into controls
// Assumes: Word already chosen between straps and override
// Notes:   Pure combinational
`timescale 1ns/1ps
module rsc_cfg_decode (
    rsc_cfg_if.dec c
);

    // ********************************************
    // Field decode
    // ********************************************
    always_comb begin
        c.agp_1x          = c.cfg[rsc_pkg::AGP_BIT]; // [R6]
        c.tv_mode         = c.cfg[rsc_pkg::TV_LSB +: 2]; // [R7]
        c.tv_enable       = (c.cfg[rsc_pkg::TV_LSB +: 2]
                             == rsc_pkg::TV_NTSC)
                            || (c.cfg[rsc_pkg::TV_LSB +: 2]
                             == rsc_pkg::TV_PAL); // [R7]
        c.xtal_14m        = c.cfg[rsc_pkg::XTAL_BIT]; // [R8]
        c.host_agp        = c.cfg[rsc_pkg::HOST_BIT];
        c.ram_128         = c.cfg[rsc_pkg::RAMW_BIT]; // [R9]
        c.pm_visible      = c.cfg[rsc_pkg::ACPI_BIT]; // [R10]
        c.device_id       = c.cfg[rsc_pkg::ACPI_BIT] ? rsc_pkg::ID_PM
                                                     : rsc_pkg::ID_LEGACY; // [R10]
        c.ram_8mbit       = c.cfg[rsc_pkg::RAMT_BIT]; // [R11]
        c.subsys_from_rom = c.cfg[rsc_pkg::SUBV_BIT]; // [R12]
        c.pci_66          = c.cfg[rsc_pkg::BUS66_BIT]; // [R14]
    end

endmodule

// ==== verification/rsc_strap_resistors.sv ====
// Purpose: Strap resistor model on the address pins
// Assumes: Pins float in reset, resistors set levels
// Notes:   Strap word chosen by the bench
`timescale 1ns/1ps
module rsc_strap_resistors (
    input  wire logic [9:0] strap_word,
    output logic      [9:0] pins
);
    // Pull resistors fix every pin level
    assign pins = strap_word;
endmodule

// ==== verification/rsc_strap_config_properties.sv ====
// Purpose: Port assertions for the strap block
// Assumes: One mclk domain, sync active-high rst
// Notes:   Bound to the top module
`timescale 1ns/1ps
module rsc_strap_config_properties (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [9:0]  framebuffer_addr_pins,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sys_bus_oe,
    input wire logic [1:0]  tv_mode,
    input wire logic        tv_enable,
    input wire logic        ram_128,
    input wire logic        fb_upper_oe,
    input wire logic        pm_visible,
    input wire logic [15:0] chip_identifier,
    input wire logic [15:0] subsys_id,
    input wire logic        pci_66
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ************
    // Checks
    // ************
    sequence oe_low_s;
        !sys_bus_oe ##1 !sys_bus_oe;
    endsequence
    bus_release_a: assert property (
        $fell(rst) |-> oe_low_s ##1 sys_bus_oe) else $error("oe timing");
    strap_capture_a: assert property (
        $rose(sys_bus_oe) |-> {pm_visible, pci_66} ==
        {$past(framebuffer_addr_pins[3], 2),
         $past(framebuffer_addr_pins[0], 2)}) else $error("strap capture");
    tv_enable_a: assert property (
        tv_mode != 2'h0 |-> tv_enable == (tv_mode != 2'h3))
        else $error("tv enable");
    dev_id_a: assert property (
        chip_identifier == (pm_visible ? rsc_pkg::ID_PM : rsc_pkg::ID_LEGACY))
        else $error("identifier");
    fb_width_a: assert property (
        fb_upper_oe == ram_128) else $error("upper lane enable");
    subsys_zero_a: assert property (
        subsys_id == 16'h0000) else $error("subsystem id");
    apb_wait_a: assert property (
        psel && penable && !pready |=> pready) else $error("no ready");
    ready_pulse_a: assert property (
        pready |=> !pready) else $error("ready too long");
    err_ready_a: assert property (
        pslverr |-> pready) else $error("error without ready");
endmodule
bind rsc_strap_config rsc_strap_config_properties u_props (
    .mclk(mclk), .rst(rst), .framebuffer_addr_pins(framebuffer_addr_pins),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .sys_bus_oe(sys_bus_oe), .tv_mode(tv_mode), .tv_enable(tv_enable),
    .ram_128(ram_128), .fb_upper_oe(fb_upper_oe), .pm_visible(pm_visible),
    .chip_identifier(chip_identifier), .subsys_id(subsys_id),
    .pci_66(pci_66)
);

// ==== verification/rsc_strap_config_tb_top.sv ====
// Purpose: Self-checking bench for the strap block
// Assumes: 10 MHz mclk, APB master task
// Notes:   Reset, override rows, access cases, then second reset
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module rsc_strap_config_tb_top;
    localparam logic [31:0] BOOT = rsc_pkg::BOOT_CFG_ADDR;
    localparam logic [31:0] INFO = rsc_pkg::DEV_INFO_ADDR;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  strap = 10'h155;
    logic [9:0]  pins;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, err, sys_bus_oe, agp_1x, xtal_14m;
    logic        ram_128, fb_upper_oe, pm_visible, ram_8mbit;
    logic        subsys_from_rom, pci_66;
    logic [1:0]  tv_mode;
    logic [15:0] chip_identifier;
    logic [15:0] svid;
    logic [9:0]  dec;
    int          failures = 0;
    int          compares = 0;
    // Rows: override word, decoded outputs
    logic [19:0] rows [4] = '{{10'h3FF, 10'h3FF}, {10'h000, 10'h000},
                              {10'h095, 10'h0B5}, {10'h36A, 10'h34A}};
    assign dec = {agp_1x, tv_mode, xtal_14m, ram_128, fb_upper_oe,
                  pm_visible, ram_8mbit, subsys_from_rom, pci_66};
    always #50 mclk = ~mclk;
    rsc_strap_resistors u_straps (.strap_word(strap), .pins(pins));
    rsc_strap_config DUT (
        .mclk(mclk), .rst(rst), .framebuffer_addr_pins(pins), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_bus_oe(sys_bus_oe), .agp_1x(agp_1x), .tv_mode(tv_mode),
        .tv_enable(), .xtal_14m(xtal_14m), .host_agp(), .ram_128(ram_128),
        .fb_upper_oe(fb_upper_oe), .pm_visible(pm_visible),
        .chip_identifier(chip_identifier), .ram_8mbit(ram_8mbit),
        .subsys_from_rom(subsys_from_rom), .subsys_vendor_id(svid),
        .subsys_id(), .subsys_rom_addr(), .pci_66(pci_66));
    // ************
    // Tasks
    // ************
    function automatic logic [9:0] dexp(input logic [9:0] c);
        return {c[9:6], c[4], c[4], c[3:0]};
    endfunction
    task automatic apb(input logic w, input logic [31:0] a, d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic print_verdict;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK(sys_bus_oe, 1'b0)
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(sys_bus_oe, 1'b1)
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        failures++;
        print_verdict();
    end
    initial begin
        do_reset();
        `CHK(dec, dexp(10'h155))
        `CHK(svid, rsc_pkg::SUBSYS_ZERO)
        apb(1'b0, BOOT, 32'h0);
        `CHK(rdat, 32'h0000_0155)
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, BOOT, {20'h0, 2'b10, rows[i][19:10]});
            apb(1'b0, BOOT, 32'h0);
            `CHK(rdat, {20'h0, 2'b10, rows[i][19:10]})
            `CHK(dec,
                 rows[i][9:0])
            `CHK(chip_identifier, rows[i][13] ? rsc_pkg::ID_PM
                 : rsc_pkg::ID_LEGACY)
        end
        $display("test override rows done");
        strap <= 10'h0F0;
        apb(1'b1, BOOT, 32'h0);
        apb(1'b0, BOOT, 32'h0);
        `CHK(rdat, 32'h0000_0155)
        `CHK(dec, dexp(10'h155))
        apb(1'b0, INFO, 32'h0);
        `CHK({err, rdat}, {17'h0, rsc_pkg::ID_LEGACY})
        apb(1'b1, INFO, 32'h0000_FFFF);
        `CHK(err, 1'b1)
        apb(1'b0, 32'h0010_1008, 32'h0);
        `CHK({err, rdat}, {1'b1, 32'h0})
        $display("test access cases done");
        apb(1'b1, BOOT, 32'h0000_0BFF);
        do_reset();
        apb(1'b0, BOOT, 32'h0);
        `CHK(rdat, 32'h0000_00F0)
        `CHK(dec, dexp(10'h0F0))
        $display("test second reset done");
        print_verdict();
    end
endmodule
